// ===== rtl/seqr_pkg.sv
// constants and carrier types for the scsi event queue reporter
package seqr_pkg;

	localparam logic [7:0]  REG_CTRL         = 8'h00;
	localparam logic [7:0]  REG_EVSIZE       = 8'h04;
	localparam logic [7:0]  REG_AN_MASK      = 8'h08;
	localparam logic [7:0]  REG_STATUS       = 8'h0c;
	localparam int          CTRL_HOTPLUG     = 0;
	localparam int          CTRL_LEGACY      = 1;
	localparam int          CTRL_GUEST_BE    = 2;
	localparam int          CTRL_PACE        = 3;
	localparam int          CTRL_EMPTY_REP   = 4;
	localparam logic [4:0]  CTRL_RESET       = 5'h10;
	localparam logic [15:0] EVSIZE_RESET     = 16'h0010;
	localparam logic [31:0] AN_MASK_RESET    = 32'h0000_0000;
	localparam int          STAT_LOST        = 0;
	localparam int          STAT_DROP_LSB    = 16;

	localparam logic [31:0] LOST_EVENTS_FLAG = 32'h8000_0000;
	localparam logic [30:0] CODE_NO_EVENT    = 31'h0000_0000;
	localparam logic [1:0]  CODE_UNIT_RESET  = 2'h1;
	localparam logic [1:0]  ASYNC_NOTICE_EVENT_CODE = 2'h2;
	localparam logic [1:0]  PARAM_CHANGE_EVENT_CODE = 2'h3;
	localparam logic [31:0] REASON_UNIT_RESET_PRESENT = 32'h0000_0000;
	localparam logic [31:0] REASON_UNIT_APPEARED      = 32'h0000_0001;
	localparam logic [31:0] REASON_UNIT_GONE          = 32'h0000_0002;
	localparam logic [4:0]  PTYPE_MULTIMEDIA = 5'h05;

	localparam logic [3:0]  KEY_ILLEGAL_REQ  = 4'h5;
	localparam logic [3:0]  KEY_UNIT_ATTN    = 4'h6;
	localparam logic [7:0]  ASC_UNIT_GONE    = 8'h25;
	localparam logic [7:0]  ASC_RESET        = 8'h29;
	localparam logic [7:0]  ASC_APPEARED     = 8'h3f;
	localparam logic [7:0]  ASCQ_APPEARED    = 8'h0e;

	localparam logic [15:0] RECORD_BYTES     = 16'h0010;
	localparam logic [1:0]  LAST_WORD        = 2'h3;

	typedef struct packed {
		logic [1:0]  code;
		logic [63:0] lun;
		logic [31:0] reason;
		logic [4:0]  ptype;
	} seqr_event_t;

	typedef struct packed {
		logic [31:0] code;
		logic [63:0] lun;
		logic [31:0] reason;
	} seqr_record_t;

	typedef struct packed {
		logic [3:0]  key;
		logic [7:0]  asc;
		logic [7:0]  ascq;
		logic [63:0] lun;
	} seqr_sense_t;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_GAP   = 3'b100
	} seqr_state_t;

endpackage : seqr_pkg

// ===== rtl/seqr_top.sv
// event record builder for the scsi event queue, with wishbone registers
`timescale 1ns/1ps
`default_nettype none
module seqr_top
	import seqr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ev_valid,
	input  wire seqr_event_t ev,
	output logic             ev_ack,
	input  wire logic        buf_valid,
	input  wire logic [15:0] buf_len,
	output logic             buf_take,
	output logic             wr_valid,
	output logic      [1:0]  wr_word,
	output logic      [31:0] wr_data,
	output logic             used_valid,
	output logic      [15:0] used_len,
	output logic             sense_valid,
	output seqr_sense_t      sense
);

	logic        [4:0]  ctrl_r;
	logic        [15:0] evsize_r;
	logic        [31:0] an_mask_r;
	logic        [15:0] drop_cnt_r;
	logic               lost_r;
	seqr_state_t        state_r;
	seqr_record_t       rec_r;
	logic        [1:0]  wcnt_r;

	logic               wb_req;
	logic               short_buf;
	logic               ev_ok;
	logic        [31:0] async_reason;
	logic               do_record;
	logic               do_empty;
	logic               do_drop;
	logic               do_discard;
	logic               do_take_ev;
	seqr_record_t       rec_nxt;

	function automatic logic [31:0] order(input logic [31:0] w, input logic swap);
		order = swap ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction : order
	function automatic logic [31:0] word_of(input seqr_record_t r, input logic [1:0] i, input logic swap);
		case (i)
			2'h0:    word_of = order(r.code, swap);
			2'h1:    word_of = r.lun[31:0];
			2'h2:    word_of = r.lun[63:32];
			default: word_of = order(r.reason, swap);
		endcase
	endfunction : word_of

	// wishbone slave: one wait state, ack for every address
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r    <= CTRL_RESET;
			evsize_r  <= EVSIZE_RESET;
			an_mask_r <= AN_MASK_RESET;
		end
		else if (wb_req && wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:
					if (wb_sel_i[0])
						ctrl_r <= wb_dat_i[4:0];
				REG_EVSIZE:
				begin
					if (wb_sel_i[0])
						evsize_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						evsize_r[15:8] <= wb_dat_i[15:8];
				end
				REG_AN_MASK:
					for (int b = 0; b < 4; b++)
						if (wb_sel_i[b])
							an_mask_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req && !wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:    wb_dat_o <= {27'h0000000, ctrl_r};
				REG_EVSIZE:  wb_dat_o <= {16'h0000, evsize_r};
				REG_AN_MASK: wb_dat_o <= an_mask_r;
				REG_STATUS:  wb_dat_o <= {drop_cnt_r, 15'h0000, lost_r};
				default:     wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// event filtering and the action taken when idle
	assign short_buf    = buf_valid && (buf_len < evsize_r);
	assign async_reason = ev.reason & an_mask_r;

	always_comb
	begin
		case (ev.code)
			CODE_UNIT_RESET:
				ev_ok = ctrl_r[CTRL_HOTPLUG] || (ev.reason == REASON_UNIT_RESET_PRESENT);
			ASYNC_NOTICE_EVENT_CODE:
				ev_ok = (async_reason != 32'h0000_0000);
			PARAM_CHANGE_EVENT_CODE:
				ev_ok = (ev.ptype != PTYPE_MULTIMEDIA);
			default:
				ev_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		do_record  = 1'b0;
		do_empty   = 1'b0;
		do_drop    = 1'b0;
		do_discard = 1'b0;
		if (state_r == ST_IDLE)
		begin
			if (short_buf)
				do_empty = 1'b1;
			else if (ev_valid && !ev_ok)
				do_drop = 1'b1;
			else if (ev_valid && buf_valid)
				do_record = 1'b1;
			else if (ev_valid && !ctrl_r[CTRL_PACE])
				do_discard = 1'b1;
			else if (lost_r && buf_valid && ctrl_r[CTRL_EMPTY_REP])
				do_empty = 1'b1;
		end
	end

	assign do_take_ev = do_record || do_drop || do_discard;

	always_comb
	begin
		rec_nxt.code   = {lost_r, CODE_NO_EVENT} | (lost_r ? LOST_EVENTS_FLAG : 32'h0000_0000);
		rec_nxt.lun    = 64'h0000_0000_0000_0000;
		rec_nxt.reason = 32'h0000_0000;
		if (do_record)
		begin
			rec_nxt.code[1:0] = ev.code;
			rec_nxt.lun       = ev.lun;
			rec_nxt.reason    = (ev.code == ASYNC_NOTICE_EVENT_CODE) ? async_reason : ev.reason;
		end
	end

	// lost flag: a discard in the same cycle as a report keeps the flag set
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			lost_r <= 1'b0;
		else if (do_discard)
			lost_r <= 1'b1;
		else if (do_record || do_empty)
			lost_r <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			drop_cnt_r <= 16'h0000;
		else if (do_discard)
			drop_cnt_r <= drop_cnt_r + 16'h0001;
	end

	// record writer: four words, then the used report
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r    <= ST_IDLE;
			rec_r      <= '0;
			wcnt_r     <= 2'h0;
			wr_valid   <= 1'b0;
			wr_word    <= 2'h0;
			wr_data    <= 32'h0000_0000;
			used_valid <= 1'b0;
			used_len   <= 16'h0000;
		end
		else
		begin
			used_valid <= 1'b0;
			case (state_r)
				ST_IDLE:
					if (do_record || do_empty)
					begin
						state_r  <= ST_WRITE;
						rec_r    <= rec_nxt;
						wcnt_r   <= 2'h0;
						wr_valid <= 1'b1;
						wr_word  <= 2'h0;
						wr_data  <= word_of(rec_nxt, 2'h0, ctrl_r[CTRL_LEGACY] && ctrl_r[CTRL_GUEST_BE]);
					end
					else if (do_drop || do_discard)
						state_r <= ST_GAP;
				ST_WRITE:
					if (wcnt_r == LAST_WORD)
					begin
						state_r    <= ST_IDLE;
						wr_valid   <= 1'b0;
						used_valid <= 1'b1;
						used_len   <= RECORD_BYTES;
					end
					else
					begin
						wcnt_r  <= wcnt_r + 2'h1;
						wr_word <= wcnt_r + 2'h1;
						wr_data <= word_of(rec_r, wcnt_r + 2'h1, ctrl_r[CTRL_LEGACY] && ctrl_r[CTRL_GUEST_BE]);
					end
				ST_GAP:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// acks are one-cycle pulses; the gap state lets sources drop valid
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev_ack   <= 1'b0;
			buf_take <= 1'b0;
		end
		else
		begin
			ev_ack   <= do_take_ev;
			buf_take <= do_record || do_empty;
		end
	end

	// sense conditions follow every accepted unit reset or param change event, even a discarded one; async notices give none
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sense_valid <= 1'b0;
			sense       <= '0;
		end
		else
		begin
			sense_valid <= 1'b0;
			if (do_record || do_discard)
			begin
				sense.lun <= ev.lun;
				case (ev.code)
					CODE_UNIT_RESET:
					begin
						sense_valid <= 1'b1;
						if (ev.reason == REASON_UNIT_GONE)
						begin
							sense.key  <= KEY_ILLEGAL_REQ;
							sense.asc  <= ASC_UNIT_GONE;
							sense.ascq <= 8'h00;
						end
						else if (ev.reason == REASON_UNIT_APPEARED)
						begin
							sense.key  <= KEY_UNIT_ATTN;
							sense.asc  <= ASC_APPEARED;
							sense.ascq <= ASCQ_APPEARED;
						end
						else
						begin
							sense.key  <= KEY_UNIT_ATTN;
							sense.asc  <= ASC_RESET;
							sense.ascq <= 8'h00;
						end
					end
					PARAM_CHANGE_EVENT_CODE:
					begin
						sense_valid <= 1'b1;
						sense.key   <= KEY_UNIT_ATTN;
						sense.asc   <= ev.reason[7:0];
						sense.ascq  <= ev.reason[15:8];
					end
					default: sense_valid <= 1'b0;
				endcase
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_used_len;
		used_valid |-> used_len == RECORD_BYTES;
	endproperty
	a_used_len: assert property (p_used_len) else $error("used length not sixteen");
	property p_four_words;
		$rose(wr_valid) |-> (wr_valid && wr_word == 2'h0) ##1 wr_valid[*3] ##1 (!wr_valid && used_valid);
	endproperty
	a_four_words: assert property (p_four_words) else $error("record not four words");
	property p_hotplug;
		(state_r == ST_WRITE && rec_r.code[1:0] == CODE_UNIT_RESET && !ctrl_r[CTRL_HOTPLUG])
			|-> rec_r.reason == REASON_UNIT_RESET_PRESENT;
	endproperty
	a_hotplug: assert property (p_hotplug) else $error("hotplug reason without capability");
	property p_no_mmc;
		(do_take_ev && ev.code == PARAM_CHANGE_EVENT_CODE && ev.ptype == PTYPE_MULTIMEDIA)
			|=> state_r == ST_GAP && !wr_valid;
	endproperty
	a_no_mmc: assert property (p_no_mmc) else $error("param change for multimedia unit");
	property p_discard_sets_lost;
		do_discard |=> lost_r && ev_ack && !buf_take && !wr_valid;
	endproperty
	a_discard_sets_lost: assert property (p_discard_sets_lost) else $error("discard did not set lost");
	property p_lost_reported;
		(lost_r && (do_record || do_empty)) |=> wr_valid && rec_r.code[31] && !lost_r
			&& wr_data == order(rec_r.code, ctrl_r[CTRL_LEGACY] && ctrl_r[CTRL_GUEST_BE]);
	endproperty
	a_lost_reported: assert property (p_lost_reported) else $error("lost flag not reported");
	property p_short_empty;
		(state_r == ST_IDLE && short_buf) |=> buf_take && rec_r.code[30:0] == CODE_NO_EVENT;
	endproperty
	a_short_empty: assert property (p_short_empty) else $error("short buffer not empty record");
	property p_sense_gone;
		(do_take_ev && ev_ok && ev.code == CODE_UNIT_RESET && ev.reason == REASON_UNIT_GONE)
			|=> sense_valid && sense.key == KEY_ILLEGAL_REQ && sense.asc == ASC_UNIT_GONE && sense.ascq == 8'h00;
	endproperty
	a_sense_gone: assert property (p_sense_gone) else $error("removal sense wrong");
	property p_pace;
		(state_r == ST_IDLE && ctrl_r[CTRL_PACE] && ev_valid && ev_ok && !buf_valid && !ev_ack) |=> !ev_ack;
	endproperty
	a_pace: assert property (p_pace) else $error("paced event taken without buffer");
	property p_async_subset;
		(state_r == ST_WRITE && rec_r.code[1:0] == ASYNC_NOTICE_EVENT_CODE)
			|-> (rec_r.reason & ~an_mask_r) == 32'h0000_0000;
	endproperty
	a_async_subset: assert property (p_async_subset) else $error("async reason outside subscription");
	property p_wb_ack;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack not one cycle");

	c_record: cover property (do_record ##1 wr_valid[*4] ##1 used_valid);
	c_discard_then_empty: cover property (do_discard ##[1:50] (do_empty && lost_r));
	c_short: cover property (state_r == ST_IDLE && short_buf);
	c_param: cover property (do_record && ev.code == PARAM_CHANGE_EVENT_CODE);
endmodule : seqr_top
`default_nettype wire

// ===== tb/seqr_driver_model.sv
// guest driver model that posts event buffers
`timescale 1ns/1ps
`default_nettype none
module seqr_driver_model
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        avail,
	input  wire logic        slow,
	input  wire logic [15:0] blen,
	input  wire logic        buf_take,
	output logic             buf_valid,
	output logic      [15:0] buf_len
);
	logic [2:0] gap_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			buf_valid <= 1'b0;
			buf_len   <= 16'h0;
			gap_r     <= 3'h0;
		end
		else if (buf_valid)
		begin
			// a posted buffer stays until taken
			if (buf_take)
			begin
				buf_valid <= 1'b0;
				gap_r     <= slow ? 3'h5 : 3'h0;
			end
		end
		else
		begin
			// nothing posted: length lines carry junk
			buf_len <= ~buf_len;
			if (gap_r != 3'h0)
				gap_r <= gap_r - 3'h1;
			else if (avail)
			begin
				buf_valid <= 1'b1;
				buf_len   <= blen;
			end
		end
	end
endmodule : seqr_driver_model
`default_nettype wire

// ===== tb/scsi_event_queue_reporter_test.sv
// self-checking bench for the scsi event queue reporter
`timescale 1ns/1ps
`default_nettype none
module scsi_event_queue_reporter_test
	import seqr_pkg::*;
();
	logic        clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ev_valid, ev_ack;
	logic        buf_valid, buf_take, wr_valid, used_valid, sense_valid, avail, slow;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, wr_data, d, r;
	logic [15:0] buf_len, blen, used_len;
	logic [15:0] lf = 16'd17060;
	logic        lun0 = 1'b0;
	logic [1:0]  wr_word;
	logic [31:0] rec [4];
	seqr_event_t ev;
	seqr_sense_t sense, s_last;
	int          num_errors = 0, num_checks = 0, rec_cnt = 0, sn_cnt = 0;

	seqr_top dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .ev_valid, .ev, .ev_ack, .buf_valid, .buf_len, .buf_take, .wr_valid,
		.wr_word, .wr_data, .used_valid, .used_len, .sense_valid, .sense);
	seqr_driver_model drv (.clock, .rst_n, .avail, .slow, .blen, .buf_take, .buf_valid, .buf_len);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		if (wr_valid)
			rec[wr_word] <= wr_data;
		if (used_valid)
		begin
			rec_cnt <= rec_cnt + 1;
			chk({16'h0, used_len}, 32'h10);
		end
		if (sense_valid)
		begin
			sn_cnt <= sn_cnt + 1;
			s_last <= sense;
		end
	end

	task automatic conclude();
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chks(input seqr_sense_t got, input seqr_sense_t exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: sense %h expected %h", $time, got, exp);
		end
	endtask : chks

	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd

	function automatic logic [31:0] sw(input logic [31:0] x, input logic be);
		return be ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
	endfunction : sw

	function automatic seqr_sense_t esense(input logic [1:0] c, input logic [31:0] v, input logic [63:0] l);
		if (c == 2'h3)
			return '{4'h6, v[7:0], v[15:8], l};
		if (v == 32'h2)
			return '{4'h5, 8'h25, 8'h00, l};
		if (v == 32'h1)
			return '{4'h6, 8'h3f, 8'h0e, l};
		return '{4'h6, 8'h29, 8'h00, l};
	endfunction : esense

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= v;
		wb_sel_i <= 4'hf;
		do @(posedge clock); while (wb_ack_o !== 1'b1 && ++n < 20);
		if (n >= 20)
		begin
			num_errors++;
			conclude();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		wb(1'b0, a, 32'h0, v);
		chk(v, e);
	endtask : rdc

	// offer an event and/or a buffer, then check record and sense
	task automatic send(input logic [1:0] c, input logic [31:0] v, input logic [4:0] pt, input logic hev,
		input logic hbuf, input logic late, input logic re, input logic se, input logic [31:0] ec,
		input logic [31:0] er);
		int r0, s0, n;
		logic [63:0] lun;
		lun = {rnd(), rnd(), rnd(), rnd()};
		if (lun0)
			lun = 64'h0;
		r0 = rec_cnt;
		s0 = sn_cnt;
		n = 0;
		@(posedge clock);
		avail <= hbuf & !late;
		// event raised only once the buffer is posted, else it would be discarded
		while (hbuf && !late && buf_valid !== 1'b1 && n < 50)
		begin
			@(posedge clock);
			n++;
		end
		ev_valid <= hev;
		ev <= '{c, lun, v, pt};
		if (late)
		begin
			// ack is a one-cycle pulse, so every edge of the wait is looked at
			repeat (10)
			begin
				@(posedge clock);
				chk({31'h0, ev_ack}, 32'h0);
			end
			avail <= 1'b1;
		end
		do @(posedge clock); while (ev_ack !== 1'b1 && buf_take !== 1'b1 && ++n < 50);
		if (n >= 50)
		begin
			num_errors++;
			conclude();
		end
		ev_valid <= 1'b0;
		avail <= 1'b0;
		repeat (6) @(posedge clock);
		chk(32'(rec_cnt - r0), {31'h0, re});
		chk(32'(sn_cnt - s0), {31'h0, se});
		if (re)
			chk(rec[0], ec);
		if (re && hev)
		begin
			chk(rec[1], lun[31:0]);
			chk(rec[2], lun[63:32]);
			chk(rec[3], er);
		end
		if (se)
			chks(s_last, esense(c, v, lun));
	endtask : send

	initial
	begin
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, ev_valid, avail, slow} = 6'h0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		ev = '0;
		blen = 16'h10;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rdc(8'h00, 32'h10);
		rdc(8'h04, 32'h10);
		rdc(8'h08, 32'h0);
		wb(1'b1, 8'h40, 32'hffff_ffff, d);
		rdc(8'h40, 32'h0);
		wb(1'b1, 8'h0c, 32'hffff_ffff, d);
		rdc(8'h0c, 32'h0);
		send(2'h1, 32'h1, 5'h0, 1, 0, 0, 0, 0, 0, 0);
		send(2'h1, 32'h2, 5'h0, 1, 0, 0, 0, 0, 0, 0);
		wb(1'b1, 8'h00, 32'h11, d);
		for (int i = 0; i < 3; i++)
			send(2'h1, 32'(i), 5'h0, 1, 1, 0, 1, 1, 32'h1, 32'(i));
		// removal of unit 0: the whole target may be gone, driver rescans
		lun0 = 1'b1;
		send(2'h1, 32'h2, 5'h0, 1, 1, 0, 1, 1, 32'h1, 32'h2);
		lun0 = 1'b0;
		wb(1'b1, 8'h08, 32'h12, d);
		send(2'h2, 32'h36, 5'h0, 1, 1, 0, 1, 0, 32'h2, 32'h12);
		send(2'h2, 32'h24, 5'h0, 1, 0, 0, 0, 0, 0, 0);
		for (int i = 0; i < 3; i++)
		begin
			r = {16'h0, rnd()};
			send(2'h3, r, 5'(i), 1, 1, 0, 1, 1, 32'h3, r);
		end
		send(2'h3, r, 5'h5, 1, 0, 0, 0, 0, 0, 0);
		wb(1'b1, 8'h00, 32'h01, d);
		send(2'h1, 32'h0, 5'h0, 1, 0, 0, 0, 1, 0, 0);
		rdc(8'h0c, 32'h0001_0001);
		send(2'h1, 32'h0, 5'h0, 1, 1, 0, 1, 1, 32'h8000_0001, 32'h0);
		wb(1'b1, 8'h00, 32'h11, d);
		send(2'h1, 32'h0, 5'h0, 1, 0, 0, 0, 1, 0, 0);
		send(2'h0, 32'h0, 5'h0, 0, 1, 0, 1, 0, 32'h8000_0000, 0);
		wb(1'b1, 8'h04, 32'h20, d);
		send(2'h0, 32'h0, 5'h0, 0, 1, 0, 1, 0, 32'h0, 0);
		wb(1'b1, 8'h04, 32'h10, d);
		rdc(8'h0c, 32'h0002_0000);
		slow <= 1'b1;
		wb(1'b1, 8'h00, 32'h19, d);
		send(2'h1, 32'h0, 5'h0, 1, 1, 1, 1, 1, 32'h1, 32'h0);
		for (int b = 0; b < 2; b++)
		begin
			wb(1'b1, 8'h00, b ? 32'h17 : 32'h13, d);
			r = {16'h0, rnd()};
			send(2'h3, r, 5'h0, 1, 1, 0, 1, 1, sw(32'h3, b[0]), sw(r, b[0]));
		end
		conclude();
	end
endmodule : scsi_event_queue_reporter_test
`default_nettype wire
